// >>> hdl/vpr_defines.vh
`ifndef VPR_DEFINES_VH
`define VPR_DEFINES_VH

// full vector addresses of the fixed sources, top of the table downward
`define VPR_VEC_RESET 16'hFFFE
`define VPR_VEC_CLKMON 16'hFFFC
`define VPR_VEC_WDOG 16'hFFFA
`define VPR_VEC_TRAP 16'hFFF8
`define VPR_VEC_SOFT 16'hFFF6
`define VPR_VEC_NMI 16'hFFF4
`define VPR_VEC_PAGE 8'hFF

// maskable sources occupy low bytes 0x80..0xF2 in steps of two
`define VPR_LOW_MIN 8'h80
`define VPR_LOW_MAX 8'hF2
`define VPR_NUM_MASKABLE 58
`define VPR_IDX_W 6

// maskable sources with their own named local enables
`define VPR_LOW_ACC_OVF 8'hDC
`define VPR_LOW_ACC_EDGE 8'hDA
`define VPR_LOW_MOTOR_OVF 8'h96
`define VPR_LOW_LOW_VOLT 8'h8A

// register map, byte addresses on the wishbone slave
`define VPR_ADR_ELEVATION 8'h00
`define VPR_ADR_STATUS 8'h04
`define VPR_ELEVATION_RESET 8'hF2

// status register fields
`define VPR_ST_VECTOR_HI 15
`define VPR_ST_VALID 16
`define VPR_ST_RESET 17
`define VPR_ST_MASKABLE 18
`define VPR_ST_PIN 19
`define VPR_ST_POR 20
`define VPR_ST_LVR 21
`define VPR_ST_ELEV_HIT 22

`define VPR_WDOG_OFF 3'h0

`endif

// >>> hdl/vpr_prio_enc.v
`timescale 1ns/1ps
// finds the highest set bit; higher index means higher vector address
module vpr_prio_enc #(
    parameter N = 58,
    parameter W = 6
) (
    input wire [N-1:0] req,
    output reg found,
    output reg [W-1:0] idx
);

integer i;

always @* begin
    found = 1'b0;
    idx = {W{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
        if (req[i]) begin
            found = 1'b1;
            idx = i[W-1:0];
        end
    end
end

endmodule

// >>> hdl/vpr_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for levels arriving from pins
module vpr_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        stage1 <= INIT;
        sync_out <= INIT;
    end else begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
end

endmodule

// >>> hdl/vpr_top.v
`timescale 1ns/1ps
`include "vpr_defines.vh"

module vpr_top #(
    parameter NUM_SRC = `VPR_NUM_MASKABLE,
    parameter IDX_W = `VPR_IDX_W
) (
    input wire clk,
    input wire resetn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire reset_pin_n,
    input wire power_on_reset,
    input wire low_voltage_reset,
    input wire clock_monitor_fail,
    input wire clock_monitor_enable,
    input wire forced_clock_monitor_enable,
    input wire watchdog_fail,
    input wire [2:0] watchdog_rate_select,
    input wire illegal_opcode_trap,
    input wire software_interrupt,
    input wire nonmaskable_request_line,
    input wire x_mask,
    input wire i_mask,
    input wire [NUM_SRC-1:0] irq_request,
    input wire [NUM_SRC-1:0] irq_enable,
    input wire accumulator_overflow_enable,
    input wire accumulator_edge_enable,
    input wire motor_timer_overflow_enable,
    input wire low_voltage_interrupt_enable,
    output reg [15:0] vector_addr,
    output reg vector_valid,
    output reg vector_reset,
    output reg vector_maskable
);

// low byte of a maskable vector to its source index
function [IDX_W-1:0] low_to_idx;
    input [7:0] low;
    reg [7:0] diff;
    begin
        diff = low - `VPR_LOW_MIN;
        low_to_idx = diff[IDX_W:1];
    end
endfunction

// index of a maskable source back to its vector low byte
function [7:0] idx_to_low;
    input [IDX_W-1:0] idx;
    reg [7:0] wide;
    begin
        wide = {{(7-IDX_W){1'b0}}, idx, 1'b0};
        idx_to_low = wide + `VPR_LOW_MIN;
    end
endfunction

// only even codes inside the maskable range name a source
function code_ok;
    input [7:0] low;
    begin
        code_ok = !low[0] && (low >= `VPR_LOW_MIN) &&
            (low <= `VPR_LOW_MAX);
    end
endfunction

localparam [IDX_W-1:0] IDX_ACC_OVF = low_to_idx(`VPR_LOW_ACC_OVF);
localparam [IDX_W-1:0] IDX_ACC_EDGE = low_to_idx(`VPR_LOW_ACC_EDGE);
localparam [IDX_W-1:0] IDX_MOTOR_OVF = low_to_idx(`VPR_LOW_MOTOR_OVF);
localparam [IDX_W-1:0] IDX_LOW_VOLT = low_to_idx(`VPR_LOW_LOW_VOLT);

// the reset pin is the only input from outside the clock domain
wire pin_reset_n_sync;

vpr_sync #(
    .WIDTH(1),
    .INIT(1'b1)
) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(reset_pin_n),
    .sync_out(pin_reset_n_sync)
);

reg [7:0] priority_elevation_register;
reg [NUM_SRC-1:0] local_enable;
reg [NUM_SRC-1:0] maskable_pending;
wire enc_found;
wire [IDX_W-1:0] enc_idx;
wire [IDX_W-1:0] elev_idx;
wire elev_hit;
wire pin_reset;
wire group_reset;
wire clkmon_req;
wire wdog_req;
wire nmi_req;
reg [15:0] next_vector;
reg next_valid;
reg next_reset;
reg next_maskable;
reg [IDX_W-1:0] pick_idx;

assign pin_reset = !pin_reset_n_sync;

// three reset causes share one vector and ignore every mask
assign group_reset = pin_reset | power_on_reset |
    low_voltage_reset;

// enabled only by their own module settings, never by the condition code
assign clkmon_req = clock_monitor_fail &
    (clock_monitor_enable | forced_clock_monitor_enable);
assign wdog_req = watchdog_fail &
    (watchdog_rate_select != `VPR_WDOG_OFF);

// X is the only mask of the nonmaskable line
assign nmi_req = nonmaskable_request_line & !x_mask;

// named enables replace the generic enable bit at their own index
always @* begin
    local_enable = irq_enable;
    local_enable[IDX_ACC_OVF] = accumulator_overflow_enable;
    local_enable[IDX_ACC_EDGE] = accumulator_edge_enable;
    local_enable[IDX_MOTOR_OVF] = motor_timer_overflow_enable;
    local_enable[IDX_LOW_VOLT] = low_voltage_interrupt_enable;
end

// the I bit gates every maskable source at once
always @* begin
    if (i_mask) begin
        maskable_pending = {NUM_SRC{1'b0}};
    end else begin
        maskable_pending = irq_request & local_enable;
    end
end

vpr_prio_enc #(
    .N(NUM_SRC),
    .W(IDX_W)
) u_enc (
    .req(maskable_pending),
    .found(enc_found),
    .idx(enc_idx)
);

// an elevated source wins only among maskables, others keep order
assign elev_idx = low_to_idx(priority_elevation_register);
assign elev_hit = code_ok(priority_elevation_register) &&
    maskable_pending[elev_idx];

always @* begin
    if (elev_hit) begin
        pick_idx = elev_idx;
    end else begin
        pick_idx = enc_idx;
    end
end

// winner classes, top of the table downward
localparam [2:0] WIN_NONE = 3'h0;
localparam [2:0] WIN_RESET = 3'h1;
localparam [2:0] WIN_CLKMON = 3'h2;
localparam [2:0] WIN_WDOG = 3'h3;
localparam [2:0] WIN_TRAP = 3'h4;
localparam [2:0] WIN_SOFT = 3'h5;
localparam [2:0] WIN_NMI = 3'h6;
localparam [2:0] WIN_MASK = 3'h7;

reg [2:0] winner;

// fixed order from the top vector downward
always @* begin
    if (group_reset) begin
        winner = WIN_RESET;
    end else if (clkmon_req) begin
        winner = WIN_CLKMON;
    end else if (wdog_req) begin
        winner = WIN_WDOG;
    end else if (illegal_opcode_trap) begin
        winner = WIN_TRAP;
    end else if (software_interrupt) begin
        winner = WIN_SOFT;
    end else if (nmi_req) begin
        winner = WIN_NMI;
    end else if (elev_hit || enc_found) begin
        winner = WIN_MASK;
    end else begin
        winner = WIN_NONE;
    end
end

// the class picks vector and flags, with pick_idx giving the maskable low byte, so the order lives in one place
always @* begin
    next_vector = 16'h0000;
    next_valid = 1'b1;
    next_reset = 1'b0;
    next_maskable = 1'b0;
    case (winner)
        WIN_RESET: begin
            next_vector = `VPR_VEC_RESET;
            next_reset = 1'b1;
        end
        WIN_CLKMON: begin
            next_vector = `VPR_VEC_CLKMON;
            next_reset = 1'b1;
        end
        WIN_WDOG: begin
            next_vector = `VPR_VEC_WDOG;
            next_reset = 1'b1;
        end
        WIN_TRAP: begin
            next_vector = `VPR_VEC_TRAP;
        end
        WIN_SOFT: begin
            next_vector = `VPR_VEC_SOFT;
        end
        WIN_NMI: begin
            next_vector = `VPR_VEC_NMI;
        end
        WIN_MASK: begin
            next_vector = {`VPR_VEC_PAGE, idx_to_low(pick_idx)};
            next_maskable = 1'b1;
        end
        default: begin
            next_valid = 1'b0;
        end
    endcase
end

// registered so the core sees a stable vector one cycle after the request
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        vector_addr <= 16'h0000;
        vector_valid <= 1'b0;
        vector_reset <= 1'b0;
        vector_maskable <= 1'b0;
    end else begin
        vector_addr <= next_vector;
        vector_valid <= next_valid;
        vector_reset <= next_reset;
        vector_maskable <= next_maskable;
    end
end

// wishbone slave: one wait state, ack drops in the cycle after it rose
wire bus_req;
wire bus_write;
reg [31:0] next_rdata;

assign bus_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
assign bus_write = bus_req & wb_we_i;

always @* begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
        `VPR_ADR_ELEVATION: begin
            next_rdata[7:0] = priority_elevation_register;
        end
        `VPR_ADR_STATUS: begin
            next_rdata[`VPR_ST_VECTOR_HI:0] = vector_addr;
            next_rdata[`VPR_ST_VALID] = vector_valid;
            next_rdata[`VPR_ST_RESET] = vector_reset;
            next_rdata[`VPR_ST_MASKABLE] = vector_maskable;
            // raw causes only; software still asks the reset generator
            next_rdata[`VPR_ST_PIN] = pin_reset;
            next_rdata[`VPR_ST_POR] = power_on_reset;
            next_rdata[`VPR_ST_LVR] = low_voltage_reset;
            next_rdata[`VPR_ST_ELEV_HIT] = elev_hit;
        end
        default: begin
            next_rdata = 32'h00000000;
        end
    endcase
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        priority_elevation_register <= `VPR_ELEVATION_RESET;
    end else begin
        wb_ack_o <= bus_req;
        if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end else begin
            wb_dat_o <= 32'h00000000;
        end
        // any code written with byte lane 0 selected is stored; an unusable one elevates nothing
        if (bus_write && wb_sel_i[0] &&
            wb_adr_i == `VPR_ADR_ELEVATION) begin
            priority_elevation_register <= wb_dat_i[7:0];
        end
    end
end

endmodule

// >>> verif/vpr_cpu_model.sv
`timescale 1ns/1ps
// core side: holds the two mask bits of the condition_code_register
module vpr_cpu_model (
    input wire clk,
    input wire resetn,
    input wire cond_load,
    input wire [1:0] cond_val,
    output reg i_mask,
    output reg x_mask
);
    // leaves reset with both masks set, so no maskable or nonmaskable-line request is taken before setup
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            i_mask <= 1'b1;
            x_mask <= 1'b1;
        end else if (cond_load) begin
            {x_mask, i_mask} <= cond_val;
        end
    end
endmodule

// >>> verif/vpr_top_sva.sv
`timescale 1ns/1ps
module vpr_top_sva #(
    parameter NUM_SRC = 58
) (
    input wire clk,
    input wire resetn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire wb_we_i,
    input wire reset_pin_n,
    input wire power_on_reset,
    input wire low_voltage_reset,
    input wire clock_monitor_fail,
    input wire clock_monitor_enable,
    input wire forced_clock_monitor_enable,
    input wire watchdog_fail,
    input wire [2:0] watchdog_rate_select,
    input wire illegal_opcode_trap,
    input wire software_interrupt,
    input wire nonmaskable_request_line,
    input wire x_mask,
    input wire i_mask,
    input wire [15:0] vector_addr,
    input wire vector_valid,
    input wire vector_reset,
    input wire vector_maskable
);
    wire cm = clock_monitor_fail &
        (clock_monitor_enable | forced_clock_monitor_enable);
    wire wd = watchdog_fail & (watchdog_rate_select != 3'h0);
    wire rs = power_on_reset | low_voltage_reset;
    wire hi = illegal_opcode_trap | software_interrupt |
        (nonmaskable_request_line & ~x_mask);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // the pin passes a two-stage sync, so its idle must be seen for a while
    sequence s_pin_idle;
        reset_pin_n [*3];
    endsequence
    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_top;
        rs |=> vector_addr == 16'hFFFE && vector_reset;
    endproperty
    property p_clkmon;
        s_pin_idle ##0 (!rs && cm) |=> vector_addr == 16'hFFFC;
    endproperty
    property p_wdog;
        s_pin_idle ##0 (!rs && !cm && wd) |=> vector_addr == 16'hFFFA;
    endproperty
    property p_masked;
        s_pin_idle ##0 (!rs && !cm && !wd && !hi && i_mask) |=> !vector_valid;
    endproperty
    property p_cause;
        vector_maskable |-> $past(!i_mask && !hi && !cm && !wd && !rs);
    endproperty
    property p_reset_flag;
        vector_reset |-> vector_addr >= 16'hFFFA && !vector_maskable;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("no ack");
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    a_top: assert property (p_top) else $error("top vector");
    a_clkmon: assert property (p_clkmon) else $error("clkmon");
    a_wdog: assert property (p_wdog) else $error("watchdog");
    a_masked: assert property (p_masked) else $error("unmasked");
    a_cause: assert property (p_cause) else $error("bad maskable");
    a_reset_flag: assert property (p_reset_flag) else $error("flag");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_maskable: cover property (vector_maskable);
    c_reset: cover property (vector_reset);
endmodule

// >>> verif/vpr_top_tb.sv
`timescale 1ns/1ps
module vpr_top_tb;
    typedef struct packed {
        logic [7:0] hi;
        logic [2:0] rt;
        logic [1:0] cc;
        logic [3:0] ne;
        logic [6:0] ra;
        logic [6:0] rb;
        logic [15:0] ex;
    } vpr_row_t;
    logic clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, reset_pin_n = 1'b1, power_on_reset = 1'b0;
    logic low_voltage_reset = 1'b0, clock_monitor_fail = 1'b0;
    logic clock_monitor_enable = 1'b0, forced_clock_monitor_enable = 1'b0;
    logic watchdog_fail = 1'b0, illegal_opcode_trap = 1'b0;
    logic software_interrupt = 1'b0, nonmaskable_request_line = 1'b0;
    logic accumulator_overflow_enable = 1'b0, accumulator_edge_enable = 1'b0;
    logic motor_timer_overflow_enable = 1'b0;
    logic low_voltage_interrupt_enable = 1'b0, cond_load = 1'b0;
    logic [1:0] cond_val = 2'h3;
    logic [2:0] watchdog_rate_select = 3'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [57:0] irq_request = 58'h0, irq_enable = {58{1'b1}};
    logic [15:0] vector_addr, v, f, g;
    logic wb_ack_o, vector_valid, vector_reset, vector_maskable;
    logic i_mask, x_mask;
    int mismatches = 0, check_count = 0, cycles = 0;
    vpr_row_t rows [13];
    vpr_top u_dut (.*);
    vpr_cpu_model u_cpu (.*);
    always #2 clk = ~clk;
    task automatic print_verdict;
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic chk_vec(input string n, input logic [15:0] e,
                           input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [57:0] req(input logic [6:0] a);
        return {57'h0, a[6]} << a[5:0];
    endfunction
    task automatic apply(input vpr_row_t a);
        @(posedge clk);
        {power_on_reset, low_voltage_reset, clock_monitor_fail,
         clock_monitor_enable, watchdog_fail, illegal_opcode_trap,
         software_interrupt, nonmaskable_request_line} <= a.hi;
        watchdog_rate_select <= a.rt;
        cond_val <= a.cc;
        {accumulator_overflow_enable, accumulator_edge_enable,
         motor_timer_overflow_enable, low_voltage_interrupt_enable} <= a.ne;
        irq_request <= req(a.ra) | req(a.rb);
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    initial begin
        rows = '{'{8'hFF, 3'h1, 2'h3, 4'h0, 7'h00, 7'h00, 16'hFFFE},
                 '{8'h40, 3'h0, 2'h3, 4'h0, 7'h00, 7'h00, 16'hFFFE},
                 '{8'h3C, 3'h1, 2'h3, 4'h0, 7'h00, 7'h00, 16'hFFFC},
                 '{8'h2C, 3'h0, 2'h3, 4'h0, 7'h00, 7'h00, 16'hFFF8},
                 '{8'h0A, 3'h7, 2'h3, 4'h0, 7'h00, 7'h00, 16'hFFFA},
                 '{8'h03, 3'h0, 2'h1, 4'h0, 7'h00, 7'h00, 16'hFFF6},
                 '{8'h01, 3'h0, 2'h1, 4'h0, 7'h79, 7'h00, 16'hFFF4},
                 '{8'h01, 3'h0, 2'h2, 4'h8, 7'h6E, 7'h00, 16'hFFDC},
                 '{8'h00, 3'h0, 2'h2, 4'h4, 7'h6E, 7'h6D, 16'hFFDA},
                 '{8'h00, 3'h0, 2'h2, 4'h3, 7'h4B, 7'h45, 16'hFF96},
                 '{8'h00, 3'h0, 2'h2, 4'h1, 7'h4B, 7'h45, 16'hFF8A},
                 '{8'h00, 3'h0, 2'h3, 4'hF, 7'h79, 7'h6E, 16'h0000},
                 '{8'h00, 3'h0, 2'h2, 4'h0, 7'h41, 7'h40, 16'hFF82}};
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        cond_load <= 1'b1;
        foreach (rows[k]) begin
            apply(rows[k]);
            settle(3);
            v = rows[k].ex;
            f = {13'h0, v != 16'h0, v >= 16'hFFFA,
                v != 16'h0 && v < 16'hFFF4};
            g = vector_valid ? vector_addr : 16'h0;
            chk_vec("vector", v, g);
            g = {13'h0, vector_valid, vector_reset, vector_maskable};
            chk_vec("flags", f, g);
        end
        apply('{8'h00, 3'h0, 2'h3, 4'h0, 7'h00, 7'h00, 16'h0});
        reset_pin_n <= 1'b0;
        settle(4);
        chk_vec("pin", 16'hFFFE, vector_addr);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        clock_monitor_fail <= 1'b1;
        forced_clock_monitor_enable <= 1'b1;
        settle(4);
        chk_vec("forced", 16'hFFFC, vector_addr);
        apply('{8'h00, 3'h0, 2'h2, 4'h9, 7'h6E, 7'h45, 16'h0});
        wb(1'b0, 8'h00, 4'hF, 32'h0);
        chk_word("elevation", 32'h000000F2, q);
        wb(1'b0, 8'h08, 4'hF, 32'h0);
        chk_word("unmapped", 32'h0, q);
        chk_vec("default", 16'hFFDC, vector_addr);
        wb(1'b1, 8'h00, 4'h1, 32'h8A);
        settle(2);
        chk_vec("raised", 16'hFF8A, vector_addr);
        wb(1'b1, 8'h00, 4'hE, 32'hDC);
        settle(2);
        chk_vec("no sel", 16'hFF8A, vector_addr);
        wb(1'b0, 8'h04, 4'hF, 32'h0);
        chk_word("status", 32'h0045FF8A, q);
        wb(1'b1, 8'h00, 4'h1, 32'hF2);
        apply('{8'h00, 3'h0, 2'h2, 4'h0, 7'h79, 7'h00, 16'h0});
        irq_enable[57] <= 1'b0;
        settle(3);
        chk_vec("disabled", 16'h0, {15'h0, vector_valid});
        @(posedge clk);
        power_on_reset <= 1'b1;
        wb(1'b0, 8'h04, 4'hF, 32'h0);
        chk_word("cause", 32'h0013FFFE, q);
        power_on_reset <= 1'b0;
        wb(1'b1, 8'h00, 4'h1, 32'h8A);
        resetn <= 1'b0;
        settle(2);
        chk_vec("reset vector", 16'h0, vector_addr);
        g = {12'h0, vector_valid, vector_reset, vector_maskable, wb_ack_o};
        chk_vec("reset flags", 16'h0, g);
        @(posedge clk);
        resetn <= 1'b1;
        wb(1'b0, 8'h00, 4'hF, 32'h0);
        chk_word("elevation reset", 32'h000000F2, q);
        print_verdict();
    end
endmodule
bind vpr_top vpr_top_sva #(.NUM_SRC(NUM_SRC)) u_sva (.*);
